// ==== logic/dhb_host_port.sv ====
// Host parallel bus port of the acquisition converter
`timescale 1ns/10ps
`include "dhb_map.svh"
module dhb_host_port
	import dhb_pkg::*;
#(
	parameter int FIFO_DEPTH = 32,
	parameter int INSTR_WORDS = 24,
	parameter int CONV_CYCLES = 44
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic rd_n_in,
	input wire logic wr_n_in,
	input wire logic cs_n_in,
	input wire logic addr_latch_in,
	input wire logic [4:0] reg_addr_lines_in,
	input wire logic bus_width_select_in,
	input wire logic [15:0] host_data_lines_in,
	output logic [15:0] host_data_lines_out,
	output logic [15:0] host_data_lines_oe_out,
	input wire logic trig_in,
	output logic trig_out,
	output logic trig_oe_out,
	input wire logic [7:0] int_event_in,
	input wire logic [15:0] conv_data_in,
	output logic int_n_out,
	output logic transfer_request_out,
	output logic clk_halt_out,
	output logic conv_busy_out
);
	localparam int CW = $clog2(CONV_CYCLES + 1);
	localparam int FW = $clog2(FIFO_DEPTH + 1);
	localparam int FA = $clog2(FIFO_DEPTH);
	localparam int IA = $clog2(INSTR_WORDS);

	initial begin
		if (FIFO_DEPTH < 2 || FIFO_DEPTH > 32) $error("dhb_host_port: FIFO_DEPTH 2..32");
		if (INSTR_WORDS < 2 || INSTR_WORDS > 24) $error("dhb_host_port: INSTR_WORDS 2..24");
		if (CONV_CYCLES < 1 || CONV_CYCLES > 255) $error("dhb_host_port: CONV_CYCLES 1..255");
	end

	logic rd_n_s, wr_n_s, cs_n_s, trig_s, ale_s;
	logic rd_n_prev_q, trig_prev_q;
	logic [4:0] addr_q, addr_s, rd_addr_q;
	logic [15:0] data_s;
	logic cs_lat_n_q;
	logic [15:0] cfg_q, mask_q, cause_q, timer_q, limit_q;
	dhb_word_t instr_mem [INSTR_WORDS];
	dhb_word_t fifo_mem [FIFO_DEPTH];
	logic [FA-1:0] wr_ptr_q, rd_ptr_q;
	logic [FW-1:0] count_q;
	logic [CW-1:0] conv_cnt_q;
	dhb_conv_t state_q;
	logic [4:0] addr_eff;
	logic sel_n, rd_act, wr_act, rd_done, conv_end, pop, start_conv;
	logic [15:0] wdata, rdata;

	dhb_sync #(.WIDTH(4), .INIT(4'hE)) u_sync (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.async_in({rd_n_in, wr_n_in, cs_n_in, trig_in}),
		.sync_out({rd_n_s, wr_n_s, cs_n_s, trig_s})
	);

	// Latch enable, address and data delayed to line up with the strobes
	dhb_sync #(.WIDTH(22), .INIT(22'h200000)) u_align (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.async_in({addr_latch_in, reg_addr_lines_in, host_data_lines_in}),
		.sync_out({ale_s, addr_s, data_s})
	);

	// Address index in word units for the width in use
	function automatic logic [4:0] word_addr(input logic [4:0] a, input logic bw);
		word_addr = bw ? {1'b0, a[4:1]} : a;
	endfunction

	function automatic logic is_instr(input logic [4:0] a, input logic bw);
		is_instr = bw ? (a[4:1] <= 4'(INSTR_WORDS / 3 - 1) ) : (a <= `DHB_ADDR_INSTR_LAST);
	endfunction

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			addr_q <= 5'h00;
			cs_lat_n_q <= 1'b1;
		end else begin
			if (ale_s) begin
				addr_q <= addr_s;
				cs_lat_n_q <= cs_n_s;
			end
		end
	end

	// Select pin ignored while the latch is closed
	assign addr_eff = ale_s ? addr_s : addr_q;
	assign sel_n = ale_s ? cs_n_s : cs_lat_n_q;
	assign rd_act = ~rd_n_s & ~sel_n;
	assign wr_act = ~wr_n_s & ~sel_n;

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			rd_n_prev_q <= 1'b1;
			trig_prev_q <= 1'b0;
			rd_addr_q <= 5'h00;
		end else begin
			rd_n_prev_q <= rd_n_s | sel_n;
			trig_prev_q <= trig_s;
			// Address of the read kept for its side effects at completion
			if (rd_act) rd_addr_q <= addr_eff;
		end
	end

	assign rd_done = (rd_n_s | sel_n) & ~rd_n_prev_q;

	always_comb begin
		wdata = data_s;
		if (bus_width_select_in) begin
			wdata = {8'h00, data_s[7:0]};
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			cfg_q <= `DHB_CFG_RESET;
			mask_q <= `DHB_MASK_RESET;
			timer_q <= 16'h0000;
			limit_q <= 16'h0000;
		end else if (wr_act) begin
			if (!is_instr(addr_eff, bus_width_select_in)) begin
				case (word_addr(addr_eff, bus_width_select_in))
					`DHB_ADDR_CONFIG: cfg_q <= wdata;
					`DHB_ADDR_INT_MASK: mask_q <= wdata;
					`DHB_ADDR_TIMER: timer_q <= wdata;
					`DHB_ADDR_LIMIT: limit_q <= wdata;
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (wr_act && is_instr(addr_eff, bus_width_select_in)) begin
			instr_mem[IA'((32'(word_addr(addr_eff, bus_width_select_in)) * 3
				+ 32'(cfg_q[`DHB_CFG_PTR_HI:`DHB_CFG_PTR_LO])) % INSTR_WORDS)] <= wdata;
		end
	end

	always_comb begin
		rdata = 16'h0000;
		if (is_instr(addr_eff, bus_width_select_in)) begin
			rdata = instr_mem[IA'((32'(word_addr(addr_eff, bus_width_select_in)) * 3
				+ 32'(cfg_q[`DHB_CFG_PTR_HI:`DHB_CFG_PTR_LO])) % INSTR_WORDS)];
		end else begin
			case (word_addr(addr_eff, bus_width_select_in))
				`DHB_ADDR_CONFIG: rdata = cfg_q;
				`DHB_ADDR_INT_MASK: rdata = mask_q;
				`DHB_ADDR_INT_CAUSE: rdata = cause_q;
				`DHB_ADDR_TIMER: rdata = timer_q;
				`DHB_ADDR_RESULT: rdata = fifo_mem[rd_ptr_q];
				`DHB_ADDR_LIMIT: rdata = limit_q;
				default: rdata = 16'h0000;
			endcase
		end
		if (bus_width_select_in && addr_eff[0]) begin
			rdata = {8'h00, rdata[15:8]};
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			host_data_lines_out <= 16'h0000;
			host_data_lines_oe_out <= 16'h0000;
		end else begin
			host_data_lines_out <= rdata;
			host_data_lines_oe_out <= rd_act ?
				(bus_width_select_in ? 16'h00FF : 16'hFFFF) : 16'h0000;
		end
	end

	// cause cleared by read, set wins
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			cause_q <= 16'h0000;
		end else if (rd_done && word_addr(rd_addr_q, bus_width_select_in) == `DHB_ADDR_INT_CAUSE
				&& !is_instr(rd_addr_q, bus_width_select_in)) begin
			cause_q <= {8'h00, int_event_in};
		end else begin
			cause_q <= cause_q | {8'h00, int_event_in};
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			int_n_out <= 1'b1;
		end else begin
			int_n_out <= ~|(cause_q[7:0] & mask_q[7:0]);
		end
	end

	assign start_conv = ~cfg_q[`DHB_CFG_TRIG_DIR] ? (trig_s & ~trig_prev_q)
		: cfg_q[`DHB_CFG_START];
	assign conv_end = (state_q == DHB_CONV) && conv_cnt_q == CW'(1);
	assign pop = rd_done && word_addr(rd_addr_q, bus_width_select_in) == `DHB_ADDR_RESULT
		&& !is_instr(rd_addr_q, bus_width_select_in) && count_q != '0;

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			state_q <= DHB_IDLE;
			conv_cnt_q <= '0;
		end else if (!sel_n) begin
			state_q <= state_q;
		end else begin
			case (state_q)
				DHB_IDLE: if (start_conv) state_q <= DHB_HOLD;
				DHB_HOLD: begin
					state_q <= DHB_CONV;
					conv_cnt_q <= CW'(CONV_CYCLES);
				end
				DHB_CONV: begin
					conv_cnt_q <= conv_cnt_q - CW'(1);
					if (conv_end) state_q <= DHB_IDLE;
				end
				default: state_q <= DHB_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (conv_end && sel_n && count_q != FW'(FIFO_DEPTH)) begin
				fifo_mem[wr_ptr_q] <= conv_data_in;
				wr_ptr_q <= FA'((32'(wr_ptr_q) + 1) % FIFO_DEPTH);
			end
			if (pop) rd_ptr_q <= FA'((32'(rd_ptr_q) + 1) % FIFO_DEPTH);
			count_q <= count_q + FW'(conv_end && sel_n && count_q != FW'(FIFO_DEPTH))
				- FW'(pop);
		end
	end

	// request at threshold, clear on empty
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			transfer_request_out <= 1'b0;
		end else if (count_q == '0) begin
			transfer_request_out <= 1'b0;
		end else if (count_q == FW'(mask_q[`DHB_MASK_THR_HI:`DHB_MASK_THR_LO])) begin
			transfer_request_out <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			trig_out <= 1'b0;
			trig_oe_out <= 1'b0;
		end else begin
			trig_oe_out <= cfg_q[`DHB_CFG_TRIG_DIR];
			// High exactly while the sequencer is in conversion
			trig_out <= sel_n ? ((state_q == DHB_HOLD) || (state_q == DHB_CONV && !conv_end))
				: (state_q == DHB_CONV);
		end
	end

	assign clk_halt_out = ~sel_n;
	assign conv_busy_out = state_q != DHB_IDLE;
endmodule

// ==== common/dhb_map.svh ====
// Address map, field positions and reset values of the host bus port
// Notes on behaviour
// - Byte width: low lanes only, upper undriven.
// - Word width: all sixteen data lanes used.
// - Drive data only while read and select low.
// - Take data only while write and select low.
// - Select low halts clocking and conversions.
// - Latch address and select on latch-enable fall.
// - Five address lines select registers, buffer, memory.
// - Trigger input rise holds, next clock starts.
// - Trigger output high during each conversion.
// - Trigger pin is input after reset.
// - Interrupt low on any unmasked condition.
// - Reading cause register clears pending interrupts.
// - Transfer request at threshold, dropped when empty.
`ifndef DHB_MAP_SVH
`define DHB_MAP_SVH
`define DHB_ADDR_INSTR_LAST 5'h07
`define DHB_ADDR_CONFIG 5'h08
`define DHB_ADDR_INT_MASK 5'h09
`define DHB_ADDR_INT_CAUSE 5'h0A
`define DHB_ADDR_TIMER 5'h0B
`define DHB_ADDR_RESULT 5'h0C
`define DHB_ADDR_LIMIT 5'h0D
`define DHB_CFG_START 0
`define DHB_CFG_TRIG_DIR 7
`define DHB_CFG_PTR_LO 8
`define DHB_CFG_PTR_HI 9
`define DHB_MASK_THR_LO 8
`define DHB_MASK_THR_HI 12
`define DHB_CFG_RESET 16'h0000
`define DHB_MASK_RESET 16'h0000
`define DHB_CONV_CYCLES 8'h2C
`endif

// ==== common/dhb_pkg.sv ====
// Types shared by the host bus port
package dhb_pkg;
	typedef enum logic [1:0] {
		DHB_IDLE,
		DHB_HOLD,
		DHB_CONV
	} dhb_conv_t;
	typedef logic [15:0] dhb_word_t;
endpackage

// ==== logic/dhb_sync.sv ====
// Two-stage synchroniser for a bundle of levels
`timescale 1ns/10ps
module dhb_sync #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	initial begin
		if (WIDTH < 1) $error("dhb_sync: WIDTH must be at least 1");
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			meta_q <= INIT;
			sync_out <= INIT;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// ==== dv/dhb_host_port_assertions.sv ====
// Pin-level checker of the host bus port
`timescale 1ns/10ps
`include "dhb_map.svh"
module dhb_host_port_chk (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic rd_n_in,
	input wire logic cs_n_in,
	input wire logic [4:0] reg_addr_lines_in,
	input wire logic bus_width_select_in,
	input wire logic [15:0] host_data_lines_oe_out,
	input wire logic trig_in,
	input wire logic trig_out,
	input wire logic trig_oe_out,
	input wire logic int_n_out,
	input wire logic clk_halt_out,
	input wire logic conv_busy_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	byte_lanes_a: assert property (|host_data_lines_oe_out && bus_width_select_in
		|-> host_data_lines_oe_out == 16'h00FF) else $error("byte lanes wrong");
	word_lanes_a: assert property (|host_data_lines_oe_out && !bus_width_select_in
		|-> host_data_lines_oe_out == 16'hFFFF) else $error("word lanes wrong");
	drive_needs_sel_a: assert property (|host_data_lines_oe_out
		|-> $past(!rd_n_in && !cs_n_in, 3)) else $error("driving without read");
	read_answer_a: assert property ((!rd_n_in && !cs_n_in)[*4]
		|-> |host_data_lines_oe_out) else $error("read not answered");
	halt_on_sel_a: assert property (!cs_n_in[*3] |-> clk_halt_out)
		else $error("clock not halted");
	conv_frozen_a: assert property ((clk_halt_out && conv_busy_out)[*3]
		|=> conv_busy_out) else $error("conversion ran while halted");
	trig_reset_a: assert property ($fell(rst_in) |-> !trig_oe_out)
		else $error("trigger not input after reset");
	trig_start_a: assert property (!trig_oe_out && !conv_busy_out && cs_n_in
		&& $rose(trig_in) |-> ##[1:6] conv_busy_out) else $error("trigger ignored");
	trig_follow_a: assert property ((trig_oe_out && conv_busy_out)[*2]
		|-> trig_out) else $error("trigger output low in conversion");
	int_release_a: assert property (!rd_n_in && !cs_n_in && !bus_width_select_in
		&& reg_addr_lines_in == `DHB_ADDR_INT_CAUSE ##1 rd_n_in |-> ##[1:6] int_n_out)
		else $error("interrupt kept after cause read");
endmodule

// ==== dv/dhb_cpu_model.sv ====
// Host processor model driving the parallel bus pins
`timescale 1ns/10ps
module dhb_cpu_model
	import dhb_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic [15:0] bus_in,
	input wire logic [15:0] oe_in,
	output logic rd_n_out,
	output logic wr_n_out,
	output logic cs_n_out,
	output logic ale_out,
	output logic [4:0] addr_out,
	output dhb_word_t data_out
);
	initial begin
		{rd_n_out, wr_n_out, cs_n_out, ale_out} = 4'hF;
		addr_out = 5'h00;
		data_out = 16'h0000;
	end
	// Released data lines never hold a value
	always @(posedge ref_clk_in) if (wr_n_out) data_out <= ~data_out;
	task automatic acc(input bit w, sel, mux, input logic [4:0] a, input dhb_word_t d,
			output dhb_word_t q);
		int n = 0;
		addr_out = a;
		if (mux) begin
			cs_n_out = !sel;
			@(posedge ref_clk_in);
			#1 ale_out = 0;
			addr_out = ~a;
		end
		{cs_n_out, rd_n_out, wr_n_out} = {!sel, w, !w};
		data_out = d;
		do begin
			@(posedge ref_clk_in);
			#1 n++;
		end while (n < 4 || (!w && sel && oe_in === 16'h0000 && n < 12));
		q = bus_in;
		{cs_n_out, rd_n_out, wr_n_out, ale_out} = 4'hF;
		addr_out = ~a;
		repeat (6) @(posedge ref_clk_in);
		#1;
	endtask
endmodule

// ==== dv/dhb_host_port_tb.sv ====
// Bench for the host bus port
`timescale 1ns/10ps
module dhb_host_port_tb
	import dhb_pkg::*;
;
	logic ref_clk_in = 0, rst_in = 1, bw = 0, trig_drv = 0;
	logic [7:0] ev = 8'h00;
	dhb_word_t cdat = 16'h0000, q, bus, hdat, dout, doe;
	logic rd_n, wr_n, cs_n, ale, trig, trig_out, trig_oe, int_n, tr, halt, busy;
	logic [4:0] addr;
	logic [4:0] wa [4] = '{5'h00, 5'h07, 5'h0D, 5'h1F};
	int fails = 0, checked = 0;
	assign bus = (dout & doe) | (hdat & ~doe);
	assign trig = trig_oe ? trig_out : trig_drv;
	always #50 ref_clk_in = ~ref_clk_in;
	dhb_host_port #(.CONV_CYCLES(12)) dut_u (.ref_clk_in, .rst_in, .rd_n_in(rd_n),
		.wr_n_in(wr_n), .cs_n_in(cs_n), .addr_latch_in(ale), .reg_addr_lines_in(addr),
		.bus_width_select_in(bw), .host_data_lines_in(bus), .host_data_lines_out(dout),
		.host_data_lines_oe_out(doe), .trig_in(trig), .trig_out, .trig_oe_out(trig_oe),
		.int_event_in(ev), .conv_data_in(cdat), .int_n_out(int_n),
		.transfer_request_out(tr), .clk_halt_out(halt), .conv_busy_out(busy));
	dhb_cpu_model cpu_u (.ref_clk_in, .bus_in(bus), .oe_in(doe), .rd_n_out(rd_n),
		.wr_n_out(wr_n), .cs_n_out(cs_n), .ale_out(ale), .addr_out(addr), .data_out(hdat));
	task automatic chk(input string s, input logic [15:0] e, a);
		checked++;
		if (a !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, a);
		end
	endtask
	task automatic results;
		if (fails == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic pulse(input logic [7:0] v);
		ev = v;
		@(posedge ref_clk_in);
		#1 ev = 8'h00;
		repeat (3) @(posedge ref_clk_in);
		#1;
	endtask
	task automatic idle;
		int n = 0;
		while (busy !== 1'b0 && n < 200) begin
			@(posedge ref_clk_in);
			#1 n++;
		end
		chk("conversion end", 16'h0001, 16'(n < 200));
		@(posedge ref_clk_in);
		#1;
	endtask
	initial begin
		#500000;
		fails++;
		results;
	end
	initial begin
		repeat (5) @(posedge ref_clk_in);
		#1 rst_in = 0;
		repeat (3) @(posedge ref_clk_in);
		#1 chk("reset outputs", 16'h0008, {int_n, tr, trig_oe, |doe});
		foreach (wa[i]) cpu_u.acc(1, 1, 0, wa[i], 16'hA5C3 ^ 16'(i), q);
		cpu_u.acc(1, 0, 0, 5'h0D, 16'h0000, q);
		foreach (wa[i]) begin
			cpu_u.acc(0, 1, 0, wa[i], 16'h0000, q);
			chk("word read", (i < 3) ? 16'hA5C3 ^ 16'(i) : 16'h0000, q);
		end
		bw = 1;
		cpu_u.acc(0, 1, 0, 5'h1A, 16'h0000, q);
		chk("low byte", 16'h00C1, q & 16'h00FF);
		cpu_u.acc(0, 1, 0, 5'h1B, 16'h0000, q);
		chk("high byte", 16'h00A5, q & 16'h00FF);
		bw = 0;
		cpu_u.acc(0, 1, 1, 5'h0D, 16'h0000, q);
		chk("latched read", 16'hA5C1, q);
		cpu_u.acc(1, 1, 0, 5'h09, 16'h0101, q);
		pulse(8'h02);
		chk("masked event", 16'h0001, int_n);
		pulse(8'h01);
		chk("unmasked event", 16'h0000, int_n);
		cpu_u.acc(0, 1, 0, 5'h0A, 16'h0000, q);
		chk("cause bit", 16'h0001, q[0]);
		chk("cause released", 16'h0001, int_n);
		cdat = 16'h1234;
		trig_drv = 1;
		repeat (6) @(posedge ref_clk_in);
		#1 chk("trigger start", 16'h0001, busy);
		cpu_u.acc(0, 1, 0, 5'h0D, 16'h0000, q);
		idle;
		trig_drv = 0;
		chk("request raised", 16'h0001, tr);
		cpu_u.acc(0, 1, 0, 5'h0C, 16'h0000, q);
		chk("result", 16'h1234, q);
		chk("request dropped", 16'h0000, tr);
		cpu_u.acc(1, 1, 0, 5'h08, 16'h0081, q);
		chk("trigger output", 16'h0001, trig_oe);
		idle;
		results;
	end
endmodule
bind dhb_host_port dhb_host_port_chk chk_u (.ref_clk_in, .rst_in, .rd_n_in, .cs_n_in,
	.reg_addr_lines_in, .bus_width_select_in, .host_data_lines_oe_out, .trig_in,
	.trig_out, .trig_oe_out, .int_n_out, .clk_halt_out, .conv_busy_out);
